// ### hdl/pcao_port_c.sv
`timescale 1ns/1ps
// port C pin override logic with apb registers
module pcao_port_c (
	input  wire logic        pclk,          // system clock
	input  wire logic        presetn,       // async reset, low
	input  wire logic        psel,          // apb select
	input  wire logic        penable,       // apb enable
	input  wire logic        pwrite,        // apb write
	input  wire logic [11:0] paddr,         // apb byte address
	input  wire logic [31:0] pwdata,        // apb write data
	output logic      [31:0] prdata,        // apb read data
	output logic             pready,        // apb ready
	output logic             pslverr,       // apb error
	input  wire logic [15:8] ext_addr_hi,   // memory address bits
	input  wire logic        ext_rd_strobe, // memory read strobe
	input  wire logic        ext_wr_strobe, // memory write strobe
	input  wire logic [7:0]  pin_in,        // pad levels
	output logic      [7:0]  pin_out,       // pad output value
	output logic      [7:0]  pin_oe,        // pad drive enable
	output logic      [7:0]  pin_pullup,    // pad pull-up on
	output logic      [7:0]  pin_ie,        // pad input buffer on
	output logic      [7:0]  pin_change_in, // pin change inputs
	output logic      [7:0]  pd_out,        // port D upper value
	output logic      [7:0]  pd_oe          // port D upper drive
);
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] port;
		logic [7:0] ddr;
		logic [7:0] pcmsk;
		logic [7:0] scan;
		logic [7:0] pin;
		logic [7:0] pout;
		logic [7:0] poe;
		logic [7:0] ppu;
		logic [7:0] pie;
		logic [7:0] pcin;
		logic [7:0] dout;
		logic [7:0] doe;
		logic [31:0] rdata;
	} pcao_port_s;
	pcao_port_s s_q, s_d;

	logic [2:0] ext_mem_release_mask;
	logic       ext_mem_enable;
	logic       test_port_enable;
	logic       pin_change_group_enable;
	logic       pud;
	logic [7:0] pin_change_mask_bit;
	logic [7:0] pullup_override_en, pullup_override_val;
	logic [7:0] direction_override_en, direction_override_val;
	logic [7:0] output_value_override_en, output_value_override_val;
	logic [7:0] input_enable_override_en, input_enable_override_val;
	logic [7:0] pu_f, dir_f, val_f, ie_f;
	logic       wr_en, rd_en, addr_ok;
	pcao_tap_if ti ();

	assign ext_mem_release_mask    = s_q.ctrl[pcao_pkg::CTL_RELMASK_LSB +: 3];
	assign ext_mem_enable          = s_q.ctrl[pcao_pkg::CTL_MEM_EN];
	assign test_port_enable        = s_q.ctrl[pcao_pkg::CTL_JEN];
	assign pin_change_group_enable = s_q.ctrl[pcao_pkg::CTL_PCIE];
	assign pud                     = s_q.ctrl[pcao_pkg::CTL_PUD];
	assign pin_change_mask_bit     = s_q.pcmsk;

	// address is valid at any mapped word offset
	function automatic logic mapped(input logic [11:0] a);
		case (a)
			pcao_pkg::OFF_CTRL, pcao_pkg::OFF_PORT, pcao_pkg::OFF_DDR, pcao_pkg::OFF_PCMSK,
			pcao_pkg::OFF_PIN, pcao_pkg::OFF_PCIN, pcao_pkg::OFF_SCAN: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction

	// test pins come off the pads; test clock is sampled, not a clock domain
	assign ti.tdi_s    = pin_in[7];
	assign ti.tms_s    = pin_in[5];
	assign ti.tck_s    = pin_in[4];
	assign ti.scan_par = s_q.scan;

	pcao_tap u_tap (
		.pclk    (pclk),
		.presetn (presetn),
		.enable  (test_port_enable),
		.t       (ti.tap)
	);

	// override enables and values per pin
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_pin
			logic addr_ov;
			assign addr_ov = ext_mem_enable && (ext_mem_release_mask < pcao_pkg::THR[g]);
			if (g >= pcao_pkg::UPPER_LO) begin : g_up
				assign pullup_override_en[g]       = addr_ov | test_port_enable;
				assign pullup_override_val[g]      = test_port_enable;
				assign direction_override_en[g]    = addr_ov | test_port_enable;
				if (g == pcao_pkg::TDO_PIN) begin : g_tdo
					assign direction_override_val[g]    = test_port_enable ? ti.tdo_drive : 1'b1;
					assign output_value_override_en[g]  = addr_ov | test_port_enable;
					assign output_value_override_val[g] = test_port_enable ? ti.tdo : ext_addr_hi[8+g];
				end else begin : g_nt
					// test inputs stay input; address drive only when port disabled
					assign direction_override_val[g]    = ~test_port_enable;
					assign output_value_override_en[g]  = addr_ov;
					assign output_value_override_val[g] = ext_addr_hi[8+g];
				end
				assign input_enable_override_en[g]  = test_port_enable |
					(pin_change_group_enable & pin_change_mask_bit[g]);
				assign input_enable_override_val[g] = test_port_enable |
					(pin_change_group_enable & pin_change_mask_bit[g]);
			end else begin : g_lo
				assign pullup_override_en[g]        = addr_ov;
				assign pullup_override_val[g]       = 1'b0;
				assign direction_override_en[g]     = addr_ov;
				assign direction_override_val[g]    = 1'b1;
				assign output_value_override_en[g]  = addr_ov;
				assign output_value_override_val[g] = ext_addr_hi[8+g];
				assign input_enable_override_en[g]  = pin_change_group_enable & pin_change_mask_bit[g];
				assign input_enable_override_val[g] = 1'b1;
			end
			// final selection between override and port registers
			assign pu_f[g]  = pullup_override_en[g] ? pullup_override_val[g]
				: (s_q.port[g] & ~s_q.ddr[g] & ~pud);
			assign dir_f[g] = direction_override_en[g] ? direction_override_val[g] : s_q.ddr[g];
			assign val_f[g] = output_value_override_en[g] ? output_value_override_val[g] : s_q.port[g];
			assign ie_f[g]  = input_enable_override_en[g] ? input_enable_override_val[g] : 1'b1;
		end
	endgenerate

	assign addr_ok = mapped(paddr);
	assign wr_en   = psel && penable && pwrite && addr_ok;
	assign rd_en   = psel && !penable && !pwrite;

	// registers, pad outputs and read data all step together
	always_comb begin
		s_d = s_q;
		s_d.pin  = pin_in & ie_f;
		s_d.pcin = pin_in & ie_f;
		s_d.pout = val_f;
		s_d.poe  = dir_f;
		s_d.ppu  = pu_f & ~dir_f;
		s_d.pie  = ie_f;
		s_d.dout = {ext_rd_strobe, ext_wr_strobe, 6'h00};
		s_d.doe  = {ext_mem_enable, ext_mem_enable, 6'h00};
		if (wr_en) begin
			case (paddr)
				pcao_pkg::OFF_CTRL:  s_d.ctrl  = pwdata[7:0];
				pcao_pkg::OFF_PORT:  s_d.port  = pwdata[7:0];
				pcao_pkg::OFF_DDR:   s_d.ddr   = pwdata[7:0];
				pcao_pkg::OFF_PCMSK: s_d.pcmsk = pwdata[7:0];
				pcao_pkg::OFF_SCAN:  s_d.scan  = pwdata[7:0];
				default: ;
			endcase
		end
		if (rd_en) begin
			case (paddr)
				pcao_pkg::OFF_CTRL:  s_d.rdata = {24'h000000, s_q.ctrl};
				pcao_pkg::OFF_PORT:  s_d.rdata = {24'h000000, s_q.port};
				pcao_pkg::OFF_DDR:   s_d.rdata = {24'h000000, s_q.ddr};
				pcao_pkg::OFF_PCMSK: s_d.rdata = {24'h000000, s_q.pcmsk};
				pcao_pkg::OFF_PIN:   s_d.rdata = {24'h000000, s_q.pin};
				pcao_pkg::OFF_PCIN:  s_d.rdata = {24'h000000, s_q.pcin};
				pcao_pkg::OFF_SCAN:  s_d.rdata = {24'h000000, s_q.scan};
				default:             s_d.rdata = 32'h00000000;
			endcase
		end
	end

	// pull-ups held on through reset: test port enable resets set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '{ctrl: pcao_pkg::CTRL_RST, ppu: 8'hb0, pie: 8'hb0, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign prdata  = s_q.rdata;
	assign pin_out = s_q.pout;
	assign pin_oe  = s_q.poe;
	assign pin_pullup    = s_q.ppu;
	assign pin_ie        = s_q.pie;
	assign pin_change_in = s_q.pcin;
	assign pd_out = s_q.dout;
	assign pd_oe  = s_q.doe;

	a_jtag_pullups: assert property (@(posedge pclk) disable iff (!presetn)
		test_port_enable |=> (pin_pullup[7] && pin_pullup[5] && pin_pullup[4])) else $error("test pull-up off");
	a_jtag_owns_pins: assert property (@(posedge pclk) disable iff (!presetn)
		(test_port_enable && $stable(test_port_enable)) |=> !pin_oe[7] && !pin_oe[5] && !pin_oe[4])
		else $error("test pin driven");
	a_addr_drive_pc0: assert property (@(posedge pclk) disable iff (!presetn)
		(ext_mem_enable && ext_mem_release_mask < 3'h7) |=> pin_oe[0] && pin_out[0] == $past(ext_addr_hi[8]))
		else $error("pc0 not address");
	a_release_pc7: assert property (@(posedge pclk) disable iff (!presetn)
		(!test_port_enable && ext_mem_release_mask >= 3'h1) |=> pin_out[7] == $past(s_q.port[7]))
		else $error("pc7 not released");
	a_lower_no_pu: assert property (@(posedge pclk) disable iff (!presetn)
		(ext_mem_enable && ext_mem_release_mask < 3'h5) |=> !pin_pullup[3] && pin_oe[3])
		else $error("pc3 pull-up on");
	a_tdo_addr14: assert property (@(posedge pclk) disable iff (!presetn)
		(!test_port_enable && ext_mem_enable && ext_mem_release_mask < 3'h2) |=> pin_out[6] == $past(ext_addr_hi[14]))
		else $error("pc6 not address 14");
	a_pin_change_buf: assert property (@(posedge pclk) disable iff (!presetn)
		(pin_change_group_enable && pin_change_mask_bit[2]) |=> pin_ie[2] && pin_change_in[2] == $past(pin_in[2]))
		else $error("pin change buffer off");
	a_port_d_strobes: assert property (@(posedge pclk) disable iff (!presetn)
		ext_mem_enable |=> pd_oe[7] && pd_out[7] == $past(ext_rd_strobe) && pd_out[6] == $past(ext_wr_strobe))
		else $error("strobes wrong");
endmodule

// ### hdl/pcao_pkg.sv
// What this block does
// - while the test port is enabled the pull-ups on the data-in, mode-select and test-clock pins stay on, even in reset.
// - while the test port is enabled the upper four pins are taken from general-purpose use.
// - the test data output is driven only in the instruction or data shift states and otherwise pulled high.
// - serial data on the test data input is shifted into the instruction register or the selected data register.
// - the test data output carries data from the instruction register or the selected data register.
// - pins seven to zero carry external address bits 15 to 8 when the memory interface uses them.
// - upper pin address override needs memory enable and a release mask below 1, 2, 3, 4 for pins seven to four.
// - lower pins override below mask 5, 6, 7, 7 for pins three to zero, forcing output with pull-up off.
// - the test data output pin drives test data when the test port is enabled, else address bit 14 when the memory interface uses it.
// - each pin's input buffer is forced on when the group enable and its mask bit are set, giving its pin-change input.
// - on the upper four pins an enabled test port overrides input enable and pull-up with its own enable value.
// - port D bit 7 is the external read strobe and bit 6 the write strobe.
package pcao_pkg;
	localparam int unsigned NPINS      = 8;
	localparam int unsigned TDO_PIN    = 6;
	localparam int unsigned UPPER_LO   = 4;
	localparam int unsigned IR_W       = 4;
	localparam int unsigned DR_W       = 8;
	localparam logic [3:0]  IR_RESET   = 4'h1;
	localparam logic [3:0]  IR_BYPASS  = 4'hf;
	localparam logic [3:0]  IR_SCAN    = 4'h2;
	// per-pin release thresholds, index = pin number
	localparam logic [2:0]  THR [NPINS] = '{3'h7, 3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1};
	// apb register byte offsets
	localparam logic [11:0] OFF_CTRL   = 12'h000;
	localparam logic [11:0] OFF_PORT   = 12'h004;
	localparam logic [11:0] OFF_DDR    = 12'h008;
	localparam logic [11:0] OFF_PCMSK  = 12'h00c;
	localparam logic [11:0] OFF_PIN    = 12'h010;
	localparam logic [11:0] OFF_PCIN   = 12'h014;
	localparam logic [11:0] OFF_SCAN   = 12'h018;
	// ctrl fields
	localparam int unsigned CTL_RELMASK_LSB = 0;
	localparam int unsigned CTL_MEM_EN      = 4;
	localparam int unsigned CTL_JEN     = 5;
	localparam int unsigned CTL_PCIE    = 6;
	localparam int unsigned CTL_PUD     = 7;
	localparam logic [7:0]  CTRL_RST    = 8'h20;
	typedef enum logic [3:0] {
		TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SHIFT_DR, TS_EX1_DR, TS_PAUSE_DR, TS_EX2_DR, TS_UPD_DR,
		TS_SEL_IR, TS_CAP_IR, TS_SHIFT_IR, TS_EX1_IR, TS_PAUSE_IR, TS_EX2_IR, TS_UPD_IR
	} pcao_tap_e;
endpackage

// ### hdl/pcao_tap_if.sv
`timescale 1ns/1ps
// test port signals between the override logic and the tap
interface pcao_tap_if;
	logic tck_s;
	logic tms_s;
	logic tdi_s;
	logic tdo;
	logic tdo_drive;
	logic [7:0] scan_par;
	modport tap (input tck_s, tms_s, tdi_s, scan_par, output tdo, tdo_drive);
	modport mux (output tck_s, tms_s, tdi_s, scan_par, input tdo, tdo_drive);
endinterface

// ### hdl/pcao_tap.sv
`timescale 1ns/1ps
// tap controller; test clock sampled as synchronous input, state advances on its rising edge
module pcao_tap (
	input  wire logic pclk,    // system clock
	input  wire logic presetn, // async reset, low
	input  wire logic enable,  // test port enabled
	pcao_tap_if.tap   t        // test pins
);
	typedef struct packed {
		pcao_pkg::pcao_tap_e st;
		logic                tck_d1;
		logic [3:0]          ir;
		logic [3:0]          irs;
		logic [7:0]          dr;
		logic                byp;
		logic                tdo;
		logic                drv;
	} pcao_tap_s;
	pcao_tap_s s_q, s_d;
	logic rise, fall;
	assign rise = t.tck_s & ~s_q.tck_d1;
	assign fall = ~t.tck_s & s_q.tck_d1;

	// state advance on tck rise, shifts on rise, tdo update on fall
	always_comb begin
		s_d = s_q;
		s_d.tck_d1 = t.tck_s;
		if (!enable) begin
			s_d.st = pcao_pkg::TS_RESET;
		end else if (rise) begin
			case (s_q.st)
				pcao_pkg::TS_RESET:    s_d.st = t.tms_s ? pcao_pkg::TS_RESET : pcao_pkg::TS_IDLE;
				pcao_pkg::TS_IDLE:     s_d.st = t.tms_s ? pcao_pkg::TS_SEL_DR : pcao_pkg::TS_IDLE;
				pcao_pkg::TS_SEL_DR:   s_d.st = t.tms_s ? pcao_pkg::TS_SEL_IR : pcao_pkg::TS_CAP_DR;
				pcao_pkg::TS_CAP_DR:   s_d.st = t.tms_s ? pcao_pkg::TS_EX1_DR : pcao_pkg::TS_SHIFT_DR;
				pcao_pkg::TS_SHIFT_DR: s_d.st = t.tms_s ? pcao_pkg::TS_EX1_DR : pcao_pkg::TS_SHIFT_DR;
				pcao_pkg::TS_EX1_DR:   s_d.st = t.tms_s ? pcao_pkg::TS_UPD_DR : pcao_pkg::TS_PAUSE_DR;
				pcao_pkg::TS_PAUSE_DR: s_d.st = t.tms_s ? pcao_pkg::TS_EX2_DR : pcao_pkg::TS_PAUSE_DR;
				pcao_pkg::TS_EX2_DR:   s_d.st = t.tms_s ? pcao_pkg::TS_UPD_DR : pcao_pkg::TS_SHIFT_DR;
				pcao_pkg::TS_UPD_DR:   s_d.st = t.tms_s ? pcao_pkg::TS_SEL_DR : pcao_pkg::TS_IDLE;
				pcao_pkg::TS_SEL_IR:   s_d.st = t.tms_s ? pcao_pkg::TS_RESET : pcao_pkg::TS_CAP_IR;
				pcao_pkg::TS_CAP_IR:   s_d.st = t.tms_s ? pcao_pkg::TS_EX1_IR : pcao_pkg::TS_SHIFT_IR;
				pcao_pkg::TS_SHIFT_IR: s_d.st = t.tms_s ? pcao_pkg::TS_EX1_IR : pcao_pkg::TS_SHIFT_IR;
				pcao_pkg::TS_EX1_IR:   s_d.st = t.tms_s ? pcao_pkg::TS_UPD_IR : pcao_pkg::TS_PAUSE_IR;
				pcao_pkg::TS_PAUSE_IR: s_d.st = t.tms_s ? pcao_pkg::TS_EX2_IR : pcao_pkg::TS_PAUSE_IR;
				pcao_pkg::TS_EX2_IR:   s_d.st = t.tms_s ? pcao_pkg::TS_UPD_IR : pcao_pkg::TS_SHIFT_IR;
				pcao_pkg::TS_UPD_IR:   s_d.st = t.tms_s ? pcao_pkg::TS_SEL_DR : pcao_pkg::TS_IDLE;
				default:               s_d.st = pcao_pkg::TS_RESET;
			endcase
			case (s_q.st)
				pcao_pkg::TS_RESET:    s_d.ir = pcao_pkg::IR_RESET;
				pcao_pkg::TS_CAP_IR:   s_d.irs = pcao_pkg::IR_RESET;
				pcao_pkg::TS_SHIFT_IR: s_d.irs = {t.tdi_s, s_q.irs[3:1]};
				pcao_pkg::TS_UPD_IR:   s_d.ir = s_q.irs;
				pcao_pkg::TS_CAP_DR: begin
					s_d.dr  = t.scan_par;
					s_d.byp = 1'b0;
				end
				pcao_pkg::TS_SHIFT_DR: begin
					if (s_q.ir == pcao_pkg::IR_SCAN)
						s_d.dr = {t.tdi_s, s_q.dr[7:1]};
					else
						s_d.byp = t.tdi_s;
				end
				default: ;
			endcase
		end else if (fall) begin
			// tdo only driven in shift states, pulled high elsewhere
			s_d.drv = (s_q.st == pcao_pkg::TS_SHIFT_IR) || (s_q.st == pcao_pkg::TS_SHIFT_DR);
			if (s_q.st == pcao_pkg::TS_SHIFT_IR)
				s_d.tdo = s_q.irs[0];
			else
				s_d.tdo = (s_q.ir == pcao_pkg::IR_SCAN) ? s_q.dr[0] : s_q.byp;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '{st: pcao_pkg::TS_RESET, ir: pcao_pkg::IR_RESET, tdo: 1'b1, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign t.tdo       = s_q.tdo;
	assign t.tdo_drive = s_q.drv;

	a_tdo_shift_only: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.drv |-> $past(s_q.st == pcao_pkg::TS_SHIFT_IR || s_q.st == pcao_pkg::TS_SHIFT_DR || s_q.drv))
		else $error("tdo driven outside shift");
	a_tap_disabled_reset: assert property (@(posedge pclk) disable iff (!presetn)
		!enable |=> s_q.st == pcao_pkg::TS_RESET) else $error("tap not reset while disabled");
	a_ir_shift_in: assert property (@(posedge pclk) disable iff (!presetn)
		(enable && rise && s_q.st == pcao_pkg::TS_SHIFT_IR) |=> s_q.irs[3] == $past(t.tdi_s))
		else $error("ir shift lost tdi");
	a_tdo_source: assert property (@(posedge pclk) disable iff (!presetn)
		(enable && fall && s_q.st == pcao_pkg::TS_SHIFT_IR) |=> s_q.tdo == $past(s_q.irs[0]))
		else $error("tdo not from ir");
endmodule

// ### tb/pcao_far_side.sv
`timescale 1ns/1ps
// memory bus engine and scan tester standing on the far side of the pins
module pcao_far_side (
	input  wire logic        pclk,          // system clock
	output logic      [7:0]  pin_in,        // pad levels seen by the block
	output logic      [15:8] ext_addr_hi,   // memory address high byte
	output logic             ext_rd_strobe, // memory read strobe
	output logic             ext_wr_strobe  // memory write strobe
);
	// pads idle high through their pull-ups; test clock stands low between frames
	initial begin
		pin_in = 8'hef;
		ext_addr_hi = 8'h00;
		ext_rd_strobe = 1'b0;
		ext_wr_strobe = 1'b0;
	end
	// one test clock period, each phase well over the two-cycle minimum
	task automatic tck_pulse(input logic tms, input logic tdi);
		@(posedge pclk);
		pin_in[5] <= tms;
		pin_in[7] <= tdi;
		repeat (4) @(posedge pclk);
		pin_in[4] <= 1'b1;
		repeat (4) @(posedge pclk);
		pin_in[4] <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask
	// plain pad levels for pin change sensing
	task automatic set_pads(input logic [7:0] v);
		@(posedge pclk);
		pin_in <= v;
	endtask
	// memory address and strobes as the bus engine would present them
	task automatic set_bus(input logic [7:0] a, input logic rd, input logic wr);
		@(posedge pclk);
		ext_addr_hi <= a;
		ext_rd_strobe <= rd;
		ext_wr_strobe <= wr;
	endtask
endmodule

// ### tb/test_port_c_alt_function_override.sv
`timescale 1ns/1ps
module test_port_c_alt_function_override;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [15:8] ext_addr_hi;
	logic        ext_rd_strobe;
	logic        ext_wr_strobe;
	logic [7:0]  pin_in;
	logic [7:0]  pin_out;
	logic [7:0]  pin_oe;
	logic [7:0]  pin_pullup;
	logic [7:0]  pin_ie;
	logic [7:0]  pin_change_in;
	logic [7:0]  pd_out;
	logic [7:0]  pd_oe;
	logic [31:0] rd;
	logic        er;
	int          mismatches;
	int          compares;
	int          cycles;
	int          thr [8] = '{7, 7, 6, 5, 4, 3, 2, 1};

	pcao_port_c i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_addr_hi(ext_addr_hi), .ext_rd_strobe(ext_rd_strobe), .ext_wr_strobe(ext_wr_strobe),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .pin_ie(pin_ie),
		.pin_change_in(pin_change_in), .pd_out(pd_out), .pd_oe(pd_oe));
	pcao_far_side i_far (.pclk(pclk), .pin_in(pin_in), .ext_addr_hi(ext_addr_hi),
		.ext_rd_strobe(ext_rd_strobe), .ext_wr_strobe(ext_wr_strobe));

	// 200 MHz system clock
	always #2.5 pclk = ~pclk;
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			give_verdict;
		end
	end
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// one apb transfer; request held until pready is seen high, only the hang guard ends a wait
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// outputs are registered, so give them a few edges to land
	task automatic settle;
		repeat (3) @(posedge pclk);
	endtask
	task automatic t_regs;
		apb(1'b0, pcao_pkg::OFF_CTRL, 32'h0);
		chk(rd, 32'h20, "ctrl reset");
		apb(1'b1, 12'h0fc, 32'hff);
		chk({31'h0, er}, 32'h1, "unmapped write err");
		apb(1'b0, 12'h0fc, 32'h0);
		chk(rd, 32'h0, "unmapped read");
	endtask
	task automatic t_test_port;
		apb(1'b1, pcao_pkg::OFF_PORT, 32'hff);
		apb(1'b1, pcao_pkg::OFF_DDR, 32'hff);
		settle;
		chk(pin_oe, 8'h0f, "upper pins not driven");
		chk(pin_pullup & 8'hb0, 8'hb0, "test pull-ups");
		chk(pin_ie & 8'hf0, 8'hf0, "test input enable");
		chk(pin_pullup[6], 1'b1, "test data out pulled high");
	endtask
	// walk the test state machine; tdi idles high
	task automatic tms_seq(input logic [7:0] tms, input int n);
		for (int i = 0; i < n; i++)
			i_far.tck_pulse(tms[i], 1'b1);
	endtask
	task automatic t_tap_shift;
		logic [7:0] scan;
		scan = 8'hc6;
		apb(1'b1, pcao_pkg::OFF_SCAN, {24'h0, scan});
		tms_seq(8'h1f, 5);
		tms_seq(8'h06, 5);
		chk(pin_oe[6], 1'b1, "drive in instruction shift");
		i_far.tck_pulse(1'b0, 1'b0);
		i_far.tck_pulse(1'b0, 1'b1);
		i_far.tck_pulse(1'b0, 1'b0);
		i_far.tck_pulse(1'b1, 1'b0);
		tms_seq(8'h03, 4);
		chk({pin_oe[6], pin_out[6]}, {1'b1, scan[0]}, "scan bit 0");
		for (int i = 1; i < 8; i++) begin
			i_far.tck_pulse(1'b0, 1'b1);
			chk(pin_out[6], scan[i], "scan bit");
		end
		i_far.tck_pulse(1'b1, 1'b1);
		chk(pin_oe[6], 1'b0, "no drive outside shift");
		tms_seq(8'h01, 2);
	endtask
	task automatic t_ext_mem;
		logic [7:0] ovr;
		logic [7:0] a;
		apb(1'b1, pcao_pkg::OFF_PORT, 32'h0);
		apb(1'b1, pcao_pkg::OFF_DDR, 32'h0);
		for (int m = 0; m < 8; m++) begin
			a = m[0] ? 8'h5a : 8'ha5;
			i_far.set_bus(a, 1'b0, 1'b0);
			apb(1'b1, pcao_pkg::OFF_CTRL, 32'h10 | m);
			for (int p = 0; p < 8; p++)
				ovr[p] = (m < thr[p]);
			settle;
			chk(pin_oe, ovr, "address drive");
			chk(pin_out, a & ovr, "address bits");
			chk(pin_pullup, 8'h00, "pull-up off");
		end
	endtask
	task automatic t_plain_port;
		apb(1'b1, pcao_pkg::OFF_CTRL, 32'h0);
		apb(1'b1, pcao_pkg::OFF_PORT, 32'ha5);
		apb(1'b1, pcao_pkg::OFF_DDR, 32'h0f);
		apb(1'b0, pcao_pkg::OFF_PORT, 32'h0);
		chk(rd, 32'ha5, "port readback");
		settle;
		chk(pin_oe, 8'h0f, "register direction");
		chk(pin_pullup, 8'ha0, "register pull-up");
	endtask
	task automatic t_pin_change;
		apb(1'b1, pcao_pkg::OFF_CTRL, 32'h40);
		apb(1'b1, pcao_pkg::OFF_PCMSK, 32'hff);
		i_far.set_pads(8'h3c);
		settle;
		chk(pin_ie, 8'hff, "buffers on");
		chk(pin_change_in, 8'h3c, "pin change inputs");
		i_far.set_pads(8'hc3);
		settle;
		chk(pin_change_in, 8'hc3, "pin change follow");
	endtask
	task automatic t_strobes;
		apb(1'b1, pcao_pkg::OFF_CTRL, 32'h10);
		i_far.set_bus(8'h00, 1'b1, 1'b0);
		settle;
		chk({pd_oe, pd_out}, 16'hc080, "read strobe");
		i_far.set_bus(8'h00, 1'b0, 1'b1);
		settle;
		chk({pd_oe, pd_out}, 16'hc040, "write strobe");
		apb(1'b1, pcao_pkg::OFF_CTRL, 32'h0);
		settle;
		chk(pd_oe, 8'h00, "strobes released");
	endtask
	// main sequence
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		mismatches = 0;
		compares = 0;
		cycles = 0;
		repeat (20) @(posedge pclk);
		chk(pin_pullup, 8'hb0, "pull-ups in reset");
		presetn <= 1'b1;
		t_regs;
		t_test_port;
		t_tap_shift;
		t_ext_mem;
		t_plain_port;
		t_pin_change;
		t_strobes;
		give_verdict;
	end
endmodule
